//--- dv/iipc_host_model.sv
// Purpose: Host controller driving the multiplexed parallel port.
// Assumes: Lines the host has released show the inverse of the last value.
// Notes:   Address, write and recovery phases are held four cycles to cover the input delay; a read polls up to eight.
`timescale 1ns/1ps
module iipc_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] port_line_out,
  input  wire logic [7:0] port_line_oe,
  output logic            chip_select_n,
  output logic            read_n,
  output logic            write_n,
  output logic            addr_latch,
  output logic [7:0]      host_port
);
  initial begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    addr_latch = 1'b0;
    host_port = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic xfer(input logic [6:0] addr, input logic wr,
                      input logic cs, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    int i;
    rdata = 8'h00;
    chip_select_n = ~cs;
    addr_latch = 1'b1;
    host_port = {wr, addr};
    step(4);
    addr_latch = 1'b0;
    host_port = wr ? wdata : ~host_port;
    if (wr) begin
      write_n = 1'b0;
      step(4);
    end else begin
      read_n = 1'b0;
      // Look just after each edge, where the registered answer has settled.
      for (i = 0; i < 8; i++) begin
        step(1);
        if (port_line_oe === 8'hFF) break;
      end
      rdata = port_line_out;
    end
    read_n = 1'b1;
    write_n = 1'b1;
    host_port = ~host_port;
    step(4);
    chip_select_n = 1'b1;
    step(1);
  endtask
endmodule

//--- dv/iipc_top_properties.sv
// Purpose: Port-level checks of the host pin control block.
// Assumes: One clock domain; counts since reset are kept locally.
// Notes:   Start-phase margins allow for the two-stage input delay.
`timescale 1ns/1ps
module iipc_top_properties #(
  parameter int CHANNELS    = 8,
  parameter int STARTUP_CYC = 1000
) (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                sync_in,
  input wire logic                chip_select_n,
  input wire logic                converter_enable,
  input wire logic                fault_undervoltage,
  input wire logic                fault_missing_voltage,
  input wire logic                fault_link,
  input wire logic                fault_overcurrent,
  input wire logic [CHANNELS-1:0] channel_level,
  input wire logic [CHANNELS-1:0] channel_indicator_out,
  input wire logic [CHANNELS-1:0] data_reg_out,
  input wire logic [CHANNELS-1:0] diag_reg_out,
  input wire logic [7:0]          port_line_oe,
  input wire logic                converter_switch_a_oe,
  input wire logic                converter_switch_b_oe,
  input wire logic                fault_out_oe,
  input wire logic                serial_active,
  input wire logic                host_enabled,
  input wire logic                shift_clk,
  input wire logic                serial_sample,
  input wire logic                serial_update
);
  logic [15:0] since_rst_reg;
  logic [15:0] since_rst_next;
  logic        any_fault;
  assign any_fault = fault_undervoltage | fault_missing_voltage |
                     fault_link | fault_overcurrent;
  // The count saturates so that the run-state checks stay armed.
  always_comb begin
    since_rst_next = since_rst_reg;
    if (since_rst_reg < 16'(STARTUP_CYC + 8)) begin
      since_rst_next = since_rst_reg + 16'h1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      since_rst_reg <= 16'h0;
    end else begin
      since_rst_reg <= since_rst_next;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence sync_held_low; !sync_in [*6]; endsequence
  sequence enable_held_off; !converter_enable [*4]; endsequence
  sequence enable_held_on; converter_enable [*4]; endsequence
  sequence cs_held_high; chip_select_n [*4]; endsequence
  a_start_serial: assert property (
    since_rst_reg < STARTUP_CYC - 1 |-> serial_active)
    else $error("serial mode not held during start");
  a_mode_latched: assert property (
    since_rst_reg > STARTUP_CYC + 2 |-> $stable(serial_active))
    else $error("mode changed after start");
  a_start_fault_off: assert property (
    since_rst_reg < STARTUP_CYC |-> !fault_out_oe)
    else $error("fault pin pulled during start");
  a_fault_or_map: assert property (
    since_rst_reg > STARTUP_CYC + 5 |-> fault_out_oe == $past(any_fault, 3))
    else $error("fault pin differs from fault sources");
  a_serial_port_quiet: assert property (
    serial_active |-> port_line_oe == 8'h00)
    else $error("parallel lines driven in serial mode");
  a_cs_refused: assert property (
    cs_held_high |-> !host_enabled && port_line_oe == 8'h00)
    else $error("host port active without chip select");
  a_switch_off: assert property (
    enable_held_off |-> !converter_switch_a_oe && !converter_switch_b_oe)
    else $error("switch driven while disabled");
  a_switch_exclusive: assert property (
    enable_held_on |-> converter_switch_a_oe != converter_switch_b_oe)
    else $error("switches not in opposite phases while enabled");
  a_sample_on_rise: assert property (
    serial_sample |-> $past(shift_clk, 2) && !$past(shift_clk, 3))
    else $error("shift sample pulse without clock rise");
  a_update_on_fall: assert property (
    serial_update |-> !$past(shift_clk, 2) && $past(shift_clk, 3))
    else $error("shift update pulse without clock fall");
  a_hold_frozen: assert property (
    sync_held_low |-> $stable(data_reg_out) && $stable(diag_reg_out))
    else $error("registers changed while sync low");
  a_indicator_follow: assert property (
    since_rst_reg > 3 |-> channel_indicator_out == $past(channel_level, 3))
    else $error("indicator differs from channel level");
endmodule
bind iipc_top iipc_top_properties #(
  .CHANNELS(CHANNELS), .STARTUP_CYC(STARTUP_CYC)) u_props (.*);

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the host pin control block.
// Assumes: Parallel mode strapped first; counts shortened by parameters.
// Notes:   A closing restart with the strap high exercises the serial
//          edge pulses.
`timescale 1ns/1ps
module tb_top;
  localparam int STARTUP = 20;
  localparam int SAMPLE  = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic mode_select, sync_in, shift_clk, converter_enable;
  logic chip_select_n, read_n, write_n, addr_latch;
  logic [7:0] host_port, port_line_out, port_line_oe, global_config_reg;
  logic [7:0] channel_level, channel_diag, channel_indicator_out;
  logic [7:0] data_reg_out, diag_reg_out, lv, dg, rd;
  logic [3:0] fault_src;
  logic converter_switch_a, converter_switch_a_oe, converter_switch_b;
  logic converter_switch_b_oe, fault_out_n, fault_out_oe, serial_active;
  logic host_enabled, serial_sample, serial_update;
  logic [31:0] lfsr_reg = 32'h0958;
  int fails = 0;
  int comparisons = 0;
  int i, j, n, ns, nu;
  always #5 sys_clk = ~sys_clk;
  iipc_top #(.SAMPLE_CYC(SAMPLE), .STARTUP_CYC(STARTUP)) u_iipc_top (.*,
    .port_line_in((port_line_oe & port_line_out) | (~port_line_oe & host_port)),
    .fault_undervoltage(fault_src[0]), .fault_missing_voltage(fault_src[1]),
    .fault_link(fault_src[2]), .fault_overcurrent(fault_src[3]));
  iipc_host_model u_iipc_host_model (.*);
  function automatic logic exp_fault(input logic [3:0] src);
    return |src;
  endfunction
  function automatic int exp_period(input int half);
    return half ? 4 * SAMPLE : 2 * SAMPLE;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic rnd(output logic [7:0] v);
    lfsr_reg = {lfsr_reg[30:0], ^(lfsr_reg & 32'h80200003)};
    v = lfsr_reg[7:0];
  endtask
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Measures cycles up to the next rise of the first switch enable.
  task automatic rise_gap(output int k);
    logic last;
    k = 0;
    last = converter_switch_a_oe;
    while (k < 100 && !(converter_switch_a_oe === 1'b1 && last === 1'b0)) begin
      last = converter_switch_a_oe;
      tick(1);
      k++;
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  initial begin
    mode_select = 1'b0;
    {sync_in, shift_clk, converter_enable, fault_src} = 7'h40;
    {channel_level, channel_diag} = 16'h0000;
    tick(20);
    rst = 1'b0;
    tick(STARTUP - 4);
    check("serial_start", 8'h01, {7'h0, serial_active});
    tick(8);
    check("serial_active", 8'h00, {7'h0, serial_active});
    mode_select = 1'b1;
    tick(8);
    check("mode_latched", 8'h00, {7'h0, serial_active});
    $display("test mode done");
    u_iipc_host_model.xfer(7'h00, 1'b1, 1'b1, 8'h01, rd);
    check("cfg_write", 8'h01, global_config_reg);
    u_iipc_host_model.xfer(7'h02, 1'b1, 1'b1, 8'hFE, rd);
    check("cfg_other_addr", 8'h01, global_config_reg);
    u_iipc_host_model.xfer(7'h00, 1'b1, 1'b0, 8'h00, rd);
    check("cfg_no_cs", 8'h01, global_config_reg);
    u_iipc_host_model.xfer(7'h00, 1'b0, 1'b1, 8'h00, rd);
    check("cfg_read", 8'h01, rd);
    $display("test write done");
    for (i = 0; i < 3; i++) begin
      rnd(lv);
      rnd(dg);
      {channel_level, channel_diag} = {lv, dg};
      tick(3 * SAMPLE + 4);
      check("data_cont", lv, data_reg_out);
      sync_in = 1'b0;
      tick(6);
      {channel_level, channel_diag} = ~{lv, dg};
      tick(3 * SAMPLE);
      check("data_reg", lv, data_reg_out);
      check("diag_reg", dg, diag_reg_out);
      check("indicator", ~lv, channel_indicator_out);
      u_iipc_host_model.xfer(7'h02, 1'b0, 1'b1, 8'h00, rd);
      check("read_data", lv, rd);
      u_iipc_host_model.xfer(7'h01, 1'b0, 1'b1, 8'h00, rd);
      check("read_diag", dg, rd);
      sync_in = 1'b1;
    end
    $display("test capture done");
    for (i = 0; i < 8; i++) begin
      rnd(lv);
      fault_src = (i < 4) ? 4'(1 << i) : (i == 4) ? 4'h0 : lv[3:0];
      tick(5);
      check("fault_pin", {7'h0, exp_fault(fault_src)}, {7'h0, fault_out_oe});
    end
    fault_src = 4'h0;
    $display("test fault done");
    converter_enable = 1'b1;
    for (i = 0; i < 2; i++) begin
      u_iipc_host_model.xfer(7'h00, 1'b1, 1'b1, 8'(1 - i), rd);
      rise_gap(n);
      rise_gap(n);
      check("switch_period", 8'(exp_period(1 - i)), 8'(n));
    end
    converter_enable = 1'b0;
    tick(5);
    check("switch_off", 8'h00, {6'h0, converter_switch_a_oe, converter_switch_b_oe});
    $display("test converter done");
    // Restart with the strap high so the serial edge points are reached.
    rst = 1'b1;
    mode_select = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(STARTUP + 4);
    check("serial_mode", 8'h01, {7'h0, serial_active});
    for (i = 0; i < 2; i++) begin
      u_iipc_host_model.chip_select_n = ~i[0];
      tick(4);
      ns = 0;
      nu = 0;
      for (j = 0; j < 4; j++) begin
        shift_clk = 1'b1;
        repeat (4) begin
          tick(1);
          ns += (serial_sample === 1'b1);
        end
        shift_clk = 1'b0;
        repeat (4) begin
          tick(1);
          nu += (serial_update === 1'b1);
        end
      end
      check("serial_sample", 8'(4 * i), 8'(ns));
      check("serial_update", 8'(4 * i), 8'(nu));
    end
    u_iipc_host_model.chip_select_n = 1'b1;
    $display("test serial done");
    give_verdict();
  end
endmodule

//--- logic/iipc_cfg.svh
// Purpose: Constants for the isolated input host pin control block.
// Assumes: Included by bare name; definitions only.
// Notes:   Cycle counts are derived from times at the 100 MHz sys_clk.
//
// Behaviour
// - Select low runs byte-wide multiplexed parallel port; high runs serial port.
// - Serial port is selected throughout the start-up phase.
// - Sync high: data and diagnostic registers update on every sample tick.
// - Isochronous: each detected sync falling edge captures fresh data and diagnostics.
// - Data and diagnostic registers freeze at the sync falling edge.
// - While sync stays low, data and diagnostic registers stay unchanged.
// - Host interface enabled and transfers allowed only while chip select low.
// - Fault output low is OR of undervoltage, missing voltage, link fail, overcurrent.
// - No fault in normal operation: fault output released high.
// - During start-up the fault output is held high.
// - Converter enable high activates the switching-converter driver.
// - Converter enable low leaves both switch outputs undriven.
// - Switch outputs toggle at sample clock rate; config bit halves that frequency.
// - Each channel indicator is on only while its input is detected high.
// - Eight port lines carry address or data per latch, strobes and top line.
// - Latch high: low seven lines give address; top line low read, high write.
// - Active-low read or write strobe starts a transfer; low is data-valid phase.
// - Serial: sample input on shift clock rise, update output on its fall.
`ifndef IIPC_CFG_SVH
`define IIPC_CFG_SVH

`define IIPC_CLK_MHZ        100
`define IIPC_SAMPLE_NS      2000
`define IIPC_SAMPLE_CYC     ((`IIPC_SAMPLE_NS * `IIPC_CLK_MHZ) / 1000)
`define IIPC_STARTUP_NS     10000
`define IIPC_STARTUP_CYC    ((`IIPC_STARTUP_NS * `IIPC_CLK_MHZ) / 1000)
`define IIPC_ADDR_W         7
`define IIPC_ADDR_RST       7'h00
`define IIPC_GLOBAL_CONFIG_REG_ADDR     7'h00
`define IIPC_GLOBAL_CONFIG_REG_HALF_BIT 0
`define IIPC_CFG_RST        8'h00
`define IIPC_DATA_RST       8'h00

`endif

//--- logic/iipc_pkg.sv
// Purpose: Types for the isolated input host pin control block.
// Assumes: Constants live in iipc_cfg.svh.
// Notes:   Holds types only.
package iipc_pkg;
  typedef enum logic [1:0] {
    IIPC_ST_START,
    IIPC_ST_RUN
  } iipc_state_t;

  typedef enum logic {
    IIPC_MODE_PARALLEL,
    IIPC_MODE_SERIAL
  } iipc_mode_t;
endpackage

//--- logic/iipc_sync2.sv
// Purpose: Two-flop synchroniser for a vector of asynchronous pins.
// Assumes: Single sys_clk domain, asynchronous active-high reset.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module iipc_sync2 #(
  parameter int          WIDTH     = 1,
  parameter logic [63:0] RESET_VAL = 64'h0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  initial begin
    if (WIDTH < 1 || WIDTH > 64) begin
      $error("iipc_sync2: WIDTH out of range");
    end
  end

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VAL[WIDTH-1:0];
      sync_reg <= RESET_VAL[WIDTH-1:0];
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

//--- logic/iipc_top.sv
// Purpose: Host-side pin control of an isolated eight-channel input device.
// Assumes: All pin inputs are asynchronous to sys_clk; the sensor-side
//          levels and fault sources arrive as pins as well.
// Notes:   The serial frame protocol itself is outside this block; only
//          its clock-edge points are produced here.
`timescale 1ns/1ps
`include "iipc_cfg.svh"
module iipc_top
  import iipc_pkg::*;
#(
  parameter int CHANNELS    = 8,
  parameter int SAMPLE_CYC  = `IIPC_SAMPLE_CYC,
  parameter int STARTUP_CYC = `IIPC_STARTUP_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                mode_select,
  input  wire logic                sync_in,
  input  wire logic                chip_select_n,
  input  wire logic                read_n,
  input  wire logic                write_n,
  input  wire logic                addr_latch,
  input  wire logic [7:0]          port_line_in,
  output logic      [7:0]          port_line_out,
  output logic      [7:0]          port_line_oe,
  input  wire logic                shift_clk,
  input  wire logic                converter_enable,
  output logic                     converter_switch_a,
  output logic                     converter_switch_a_oe,
  output logic                     converter_switch_b,
  output logic                     converter_switch_b_oe,
  input  wire logic                fault_undervoltage,
  input  wire logic                fault_missing_voltage,
  input  wire logic                fault_link,
  input  wire logic                fault_overcurrent,
  output logic                     fault_out_n,
  output logic                     fault_out_oe,
  input  wire logic [CHANNELS-1:0] channel_level,
  input  wire logic [CHANNELS-1:0] channel_diag,
  output logic      [CHANNELS-1:0] channel_indicator_out,
  output logic      [CHANNELS-1:0] data_reg_out,
  output logic      [CHANNELS-1:0] diag_reg_out,
  output logic                     serial_active,
  output logic                     host_enabled,
  output logic                     serial_sample,
  output logic                     serial_update,
  output logic      [7:0]          global_config_reg
);
  localparam int PW = 10 + 2 * CHANNELS;

  initial begin
    if (CHANNELS != 8) begin
      $error("iipc_top: port is byte wide, CHANNELS must be 8");
    end
    if (SAMPLE_CYC < 2 || SAMPLE_CYC > 65536 ||
        STARTUP_CYC < 1 || STARTUP_CYC > 65535) begin
      $error("iipc_top: timing counts out of range");
    end
  end

  // All asynchronous pins pass two flops before any logic reads them.
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  assign pin_raw = {channel_diag, channel_level, fault_overcurrent,
                    fault_link, fault_missing_voltage, fault_undervoltage,
                    converter_enable, shift_clk, addr_latch, write_n,
                    read_n, chip_select_n};

  // Strobes and chip select reset to their idle high level, the latch
  // strobe to its idle low level, so no false phase follows reset.
  iipc_sync2 #(.WIDTH(PW), .RESET_VAL(64'h07)) u_pins (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  // Sync and mode select reset high like their pull-ups.
  logic [1:0] ctl_s;
  iipc_sync2 #(.WIDTH(2), .RESET_VAL(64'h3)) u_ctl (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({sync_in, mode_select}),
    .sync_out (ctl_s)
  );

  logic [7:0] port_s;
  iipc_sync2 #(.WIDTH(8), .RESET_VAL(64'h0)) u_port (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (port_line_in),
    .sync_out (port_s)
  );

  logic                cs_n_s, rd_n_s, wr_n_s, ale_s, sck_s, dcen_s;
  logic                uv_s, mv_s, te_s, oc_s, sync_s, sel_s;
  logic [CHANNELS-1:0] lvl_s, dia_s;
  assign {dia_s, lvl_s, oc_s, te_s, mv_s, uv_s, dcen_s, sck_s, ale_s,
          wr_n_s, rd_n_s, cs_n_s} = pin_s;
  assign {sync_s, sel_s} = ctl_s;

  iipc_state_t         state_reg, state_next;
  logic [15:0]         start_cnt_reg, start_cnt_next;
  iipc_mode_t          mode_reg, mode_next;
  logic [15:0]         tick_cnt_reg, tick_cnt_next;
  logic                sync_d_reg, sync_d_next;
  logic                sck_d_reg, sck_d_next;
  logic [CHANNELS-1:0] data_reg, data_next;
  logic [CHANNELS-1:0] diag_reg, diag_next;
  logic [CHANNELS-1:0] ind_reg, ind_next;
  logic [`IIPC_ADDR_W-1:0] addr_reg, addr_next;
  logic                wdir_reg, wdir_next;
  logic [7:0]          cfg_reg, cfg_next;
  logic [7:0]          pout_reg, pout_next;
  logic                poe_reg, poe_next;
  logic                sw_reg, sw_next;
  logic                half_reg, half_next;
  logic                fault_reg, fault_next;
  logic                tick;
  logic                fall;

  assign tick = (tick_cnt_reg == 16'(SAMPLE_CYC - 1));
  assign fall = sync_d_reg && !sync_s;

  always_comb begin
    state_next     = state_reg;
    start_cnt_next = start_cnt_reg;
    mode_next      = mode_reg;
    case (state_reg)
      IIPC_ST_START: begin
        mode_next = IIPC_MODE_SERIAL;
        if (start_cnt_reg == 16'(STARTUP_CYC - 1)) begin
          state_next = IIPC_ST_RUN;
          // Taken once, so a later change on the pin is ignored.
          mode_next = sel_s ? IIPC_MODE_SERIAL : IIPC_MODE_PARALLEL;
        end else begin
          start_cnt_next = start_cnt_reg + 16'h0001;
        end
      end
      IIPC_ST_RUN: begin
        mode_next = mode_reg;
      end
      default: begin
        state_next = IIPC_ST_START;
      end
    endcase
  end

  always_comb begin
    tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    sync_d_next   = sync_s;
    sck_d_next    = sck_s;
    data_next     = data_reg;
    diag_next     = diag_reg;
    ind_next      = lvl_s;
    if (fall) begin
      data_next = lvl_s;
      diag_next = dia_s;
    end else if (sync_s && tick) begin
      data_next = lvl_s;
      diag_next = dia_s;
    end
    // With sync low and no edge, both registers simply hold.
  end

  logic hen;
  assign hen = !cs_n_s && (state_reg == IIPC_ST_RUN);

  always_comb begin
    addr_next = addr_reg;
    wdir_next = wdir_reg;
    cfg_next  = cfg_reg;
    pout_next = pout_reg;
    poe_next  = 1'b0;
    if (hen && mode_reg == IIPC_MODE_PARALLEL) begin
      if (ale_s) begin
        addr_next = port_s[`IIPC_ADDR_W-1:0];
        wdir_next = port_s[7];
      end else if (!rd_n_s && !wdir_reg) begin
        poe_next = 1'b1;
        if (addr_reg == `IIPC_GLOBAL_CONFIG_REG_ADDR) begin
          pout_next = cfg_reg;
        end else if (addr_reg[0]) begin
          pout_next = diag_reg;
        end else begin
          pout_next = data_reg;
        end
      end else if (!wr_n_s && wdir_reg &&
                   addr_reg == `IIPC_GLOBAL_CONFIG_REG_ADDR) begin
        cfg_next = port_s;
      end
    end
  end

  always_comb begin
    sw_next   = sw_reg;
    half_next = half_reg;
    if (dcen_s && tick) begin
      if (cfg_reg[`IIPC_GLOBAL_CONFIG_REG_HALF_BIT]) begin
        half_next = !half_reg;
        if (half_reg) begin
          sw_next = !sw_reg;
        end
      end else begin
        sw_next = !sw_reg;
      end
    end
    // Faults only count once start-up is over; the pin is released before.
    fault_next = (state_reg == IIPC_ST_RUN) &&
                 (uv_s || mv_s || te_s || oc_s);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= IIPC_ST_START;
      start_cnt_reg <= 16'h0000;
      mode_reg      <= IIPC_MODE_SERIAL;
      tick_cnt_reg  <= 16'h0000;
      sync_d_reg    <= 1'b1;
      sck_d_reg     <= 1'b0;
      data_reg      <= `IIPC_DATA_RST;
      diag_reg      <= `IIPC_DATA_RST;
      ind_reg       <= `IIPC_DATA_RST;
      addr_reg      <= `IIPC_ADDR_RST;
      wdir_reg      <= 1'b0;
      cfg_reg       <= `IIPC_CFG_RST;
      pout_reg      <= 8'h00;
      poe_reg       <= 1'b0;
      sw_reg        <= 1'b0;
      half_reg      <= 1'b0;
      fault_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      start_cnt_reg <= start_cnt_next;
      mode_reg      <= mode_next;
      tick_cnt_reg  <= tick_cnt_next;
      sync_d_reg    <= sync_d_next;
      sck_d_reg     <= sck_d_next;
      data_reg      <= data_next;
      diag_reg      <= diag_next;
      ind_reg       <= ind_next;
      addr_reg      <= addr_next;
      wdir_reg      <= wdir_next;
      cfg_reg       <= cfg_next;
      pout_reg      <= pout_next;
      poe_reg       <= poe_next;
      sw_reg        <= sw_next;
      half_reg      <= half_next;
      fault_reg     <= fault_next;
    end
  end

  assign port_line_out         = pout_reg;
  assign port_line_oe          = {8{poe_reg}};
  // Open-drain switches: each pulls low in its own half period.
  assign converter_switch_a    = 1'b0;
  assign converter_switch_b    = 1'b0;
  assign converter_switch_a_oe = dcen_s && sw_reg;
  assign converter_switch_b_oe = dcen_s && !sw_reg;
  assign fault_out_n           = 1'b0;
  assign fault_out_oe          = fault_reg;
  assign channel_indicator_out = ind_reg;
  assign data_reg_out          = data_reg;
  assign diag_reg_out          = diag_reg;
  assign serial_active         = (mode_reg == IIPC_MODE_SERIAL);
  assign host_enabled          = hen;
  assign serial_sample = hen && serial_active && sck_s && !sck_d_reg;
  assign serial_update = hen && serial_active && !sck_s && sck_d_reg;
  assign global_config_reg     = cfg_reg;
endmodule
